// ### logic/plm_listen_ctrl.sv
`timescale 1ns/10ps
module plm_listen_ctrl #(
	parameter int SYNC_W        = 32,
	parameter int RES_FINE_CYC  = plm_pkg::RES_FINE_CYC,
	parameter int RES_MID_CYC   = plm_pkg::RES_MID_CYC,
	parameter int RES_LONG_CYC  = plm_pkg::RES_LONG_CYC,
	parameter int RC_TRIM_CYC   = plm_pkg::RC_TRIM_CYC
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire plm_pkg::plm_op_mode_t   operating_mode_i,
	input  wire plm_pkg::plm_listen_cfg_t listen_cfg_i,
	input  wire plm_pkg::plm_auto_cfg_t  auto_cfg_i,
	input  wire logic [7:0]              post_detect_timeout_count_i,
	input  wire logic                    signal_level_threshold_i,
	input  wire logic                    payload_complete_flag_i,
	input  wire logic                    checksum_good_flag_i,
	input  wire logic                    queue_has_bytes_i,
	input  wire logic                    bit_tick_i,
	input  wire logic                    bit_data_i,
	input  wire logic [SYNC_W-1:0]       sync_word_i,
	input  wire logic                    rc_trim_trigger_i,
	output logic [2:0]                   active_mode_o,
	output logic                         rx_on_o,
	output logic                         rc_only_o,
	output logic                         listen_active_o,
	output logic                         listen_stopped_o,
	output logic                         queue_discard_o,
	output logic                         timeout_o,
	output logic                         pattern_match_flag_o,
	output logic                         rc_trim_busy_o,
	output logic                         rc_trim_finished_o
);
	typedef enum logic [2:0] {
		PLM_NORMAL,
		PLM_IDLE,
		PLM_RX,
		PLM_HOLD,
		PLM_STOPPED
	} plm_state_t;

	function automatic logic [31:0] step_of(input logic [1:0] res);
		case (res)
			plm_pkg::RES_FINE: step_of = 32'(RES_FINE_CYC);
			plm_pkg::RES_MID:  step_of = 32'(RES_MID_CYC);
			plm_pkg::RES_LONG: step_of = 32'(RES_LONG_CYC);
			default:           step_of = 32'h0;
		endcase
	endfunction : step_of

	plm_state_t        state_ff,   nxt_state;
	logic [2:0]        mode_ff,    nxt_mode;
	logic [2:0]        stop_mode_ff, nxt_stop_mode;
	logic              inter_ff,   nxt_inter;
	logic              discard_ff, nxt_discard;
	logic              tmr_start,  tmr_abort;
	logic [31:0]       tmr_step;
	logic [7:0]        tmr_coef;
	logic              tmr_done;
	logic              tmr_busy;

	logic              rssi_d_ff,  nxt_rssi_d;
	logic              queue_d_ff, nxt_queue_d;
	logic              to_arm_ff,  nxt_to_arm;
	logic [11:0]       to_cnt_ff,  nxt_to_cnt;
	logic              to_ff,      nxt_to;
	logic [SYNC_W-1:0] shift_ff,   nxt_shift;
	logic              match_ff,   nxt_match;

	logic              rc_busy_ff, nxt_rc_busy;
	logic              rc_done_ff, nxt_rc_done;
	logic [31:0]       rc_cnt_ff,  nxt_rc_cnt;

	logic              accepted;
	logic              in_listen;
	logic              rx_now;
	logic [11:0]       to_target;

	plm_phase_timer u_timer (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.start_i (tmr_start),
		.abort_i (tmr_abort),
		.step_i  (tmr_step),
		.coef_i  (tmr_coef),
		.done_o  (tmr_done),
		.busy_o  (tmr_busy)
	);

	// listen sequencer
	always_comb begin
		nxt_state     = state_ff;
		nxt_stop_mode = stop_mode_ff;
		nxt_inter     = inter_ff;
		nxt_discard   = 1'b0;
		tmr_start     = 1'b0;
		tmr_abort     = 1'b0;
		tmr_step      = step_of(listen_cfg_i.idle_res);
		tmr_coef      = listen_cfg_i.idle_coef;
		in_listen     = (state_ff != PLM_NORMAL);
		// level alone, or level plus sync match
		accepted      = signal_level_threshold_i &&
		                (!listen_cfg_i.criteria || match_ff);
		if (in_listen && (operating_mode_i.listen_cancel ||
		    !operating_mode_i.listen_enable)) begin
			// cancel or cleared enable returns to the mode field
			nxt_state = PLM_NORMAL;
			tmr_abort = 1'b1;
		end else begin
			case (state_ff)
				PLM_NORMAL: begin
					// only armed from standby, cancel low
					if (operating_mode_i.listen_enable && !operating_mode_i.listen_cancel &&
					    mode_ff == plm_pkg::MODE_STBY) begin
						nxt_state = PLM_IDLE;
						nxt_inter = 1'b0;
						tmr_start = 1'b1;
					end else if (auto_cfg_i.enable) begin
						// entry on good checksum, leave on queue drained
						if (!inter_ff && checksum_good_flag_i) begin
							nxt_inter = 1'b1;
						end else if (inter_ff && queue_d_ff && !queue_has_bytes_i) begin
							nxt_inter = 1'b0;
						end
					end else begin
						nxt_inter = 1'b0;
					end
				end
				PLM_IDLE: begin
					// idle ends, receiver woken for a window
					if (tmr_done) begin
						nxt_state   = PLM_RX;
						tmr_start   = 1'b1;
						tmr_step    = step_of(listen_cfg_i.rx_res);
						tmr_coef    = listen_cfg_i.rx_coef;
						// stale bytes dropped at each wake-up
						nxt_discard = 1'b1;
					end
				end
				PLM_RX: begin
					// window includes receiver start-up, timer started on wake
					if (accepted) begin
						// receiver kept on, window timer dropped
						nxt_state = (listen_cfg_i.end_action == plm_pkg::END_STAY) ?
						            PLM_STOPPED : PLM_HOLD;
						nxt_stop_mode = plm_pkg::MODE_RX;
						tmr_abort = 1'b1;
					end else if (tmr_done) begin
						// nothing heard: receiver off till next period
						nxt_state = PLM_IDLE;
						tmr_start = 1'b1;
					end
				end
				PLM_HOLD: begin
					if (payload_complete_flag_i || to_ff) begin
						if (listen_cfg_i.end_action == plm_pkg::END_RESUME) begin
							nxt_state = PLM_IDLE;
							tmr_start = 1'b1;
						end else begin
							nxt_state     = PLM_STOPPED;
							nxt_stop_mode = mode_ff;
						end
					end
				end
				PLM_STOPPED: begin
					// held until host clears enable or sets cancel
					nxt_state = PLM_STOPPED;
				end
				default: begin
					nxt_state = PLM_NORMAL;
				end
			endcase
		end
	end

	// effective mode: base field, intermediate, or listen phase
	always_comb begin
		nxt_mode = operating_mode_i.mode;
		case (nxt_state)
			PLM_NORMAL:  rx_now = ((nxt_inter ? auto_cfg_i.intermediate : nxt_mode) ==
			                       plm_pkg::MODE_RX);
			PLM_IDLE:    rx_now = 1'b0;
			PLM_RX:      rx_now = 1'b1;
			PLM_HOLD:    rx_now = 1'b1;
			PLM_STOPPED: rx_now = (nxt_stop_mode == plm_pkg::MODE_RX);
			default:     rx_now = 1'b0;
		endcase
	end

	// post-detect timeout and sync correlator
	always_comb begin
		to_target   = {post_detect_timeout_count_i, 4'h0};
		nxt_rssi_d  = signal_level_threshold_i;
		nxt_queue_d = queue_has_bytes_i;
		nxt_to_arm  = to_arm_ff;
		nxt_to_cnt  = to_cnt_ff;
		nxt_to      = 1'b0;
		nxt_shift   = shift_ff;
		nxt_match   = match_ff;
		if (!rx_on_o) begin
			nxt_to_arm = 1'b0;
		end else if (signal_level_threshold_i && !rssi_d_ff) begin
			// zero count disables the timeout
			nxt_to_arm = (post_detect_timeout_count_i != 8'h0);
			nxt_to_cnt = 12'h0;
		end else if (to_arm_ff && bit_tick_i) begin
			if (to_cnt_ff == to_target - 12'h1) begin
				nxt_to     = 1'b1;
				nxt_to_arm = 1'b0;
			end else begin
				nxt_to_cnt = to_cnt_ff + 12'h1;
			end
		end
		if (!rx_on_o) begin
			nxt_match = 1'b0;
		end
		if (rx_on_o && bit_tick_i) begin
			nxt_shift = {shift_ff[SYNC_W-2:0], bit_data_i};
			// set wins over the rx-off clear
			if ({shift_ff[SYNC_W-2:0], bit_data_i} == sync_word_i) begin
				nxt_match = 1'b1;
			end
		end
	end

	// rc trim: starts busy out of reset
	always_comb begin
		nxt_rc_busy = rc_busy_ff;
		nxt_rc_done = rc_done_ff;
		nxt_rc_cnt  = rc_cnt_ff;
		if (rc_trim_trigger_i) begin
			// retrigger restarts the run
			nxt_rc_busy = 1'b1;
			nxt_rc_done = 1'b0;
			nxt_rc_cnt  = 32'h0;
		end else if (rc_busy_ff) begin
			if (rc_cnt_ff == 32'(RC_TRIM_CYC - 1)) begin
				nxt_rc_busy = 1'b0;
				nxt_rc_done = 1'b1;
			end else begin
				nxt_rc_cnt = rc_cnt_ff + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_ff     <= PLM_NORMAL;
			mode_ff      <= plm_pkg::MODE_STBY;
			stop_mode_ff <= plm_pkg::MODE_STBY;
			inter_ff     <= 1'b0;
			discard_ff   <= 1'b0;
			rssi_d_ff    <= 1'b0;
			queue_d_ff   <= 1'b0;
			to_arm_ff    <= 1'b0;
			to_cnt_ff    <= 12'h0;
			to_ff        <= 1'b0;
			shift_ff     <= '0;
			match_ff     <= 1'b0;
			rc_busy_ff   <= plm_pkg::RC_BUSY_RST;
			rc_done_ff   <= plm_pkg::RC_DONE_RST;
			rc_cnt_ff    <= 32'h0;
		end else begin
			state_ff     <= nxt_state;
			mode_ff      <= nxt_mode;
			stop_mode_ff <= nxt_stop_mode;
			inter_ff     <= nxt_inter;
			discard_ff   <= nxt_discard;
			rssi_d_ff    <= nxt_rssi_d;
			queue_d_ff   <= nxt_queue_d;
			to_arm_ff    <= nxt_to_arm;
			to_cnt_ff    <= nxt_to_cnt;
			to_ff        <= nxt_to;
			shift_ff     <= nxt_shift;
			match_ff     <= nxt_match;
			rc_busy_ff   <= nxt_rc_busy;
			rc_done_ff   <= nxt_rc_done;
			rc_cnt_ff    <= nxt_rc_cnt;
		end
	end

	// registered outputs; active mode decodes the field values
	logic [2:0] act_ff,  nxt_act;
	logic       rx_ff;
	logic       rc_ff,   nxt_rc;
	logic       lact_ff, nxt_lact;
	logic       lstp_ff, nxt_lstp;

	always_comb begin
		nxt_rc   = (nxt_state == PLM_IDLE);
		nxt_lact = (nxt_state != PLM_NORMAL);
		nxt_lstp = (nxt_state == PLM_STOPPED);
		case (nxt_state)
			PLM_NORMAL:  nxt_act = nxt_inter ? auto_cfg_i.intermediate : nxt_mode;
			PLM_IDLE:    nxt_act = plm_pkg::MODE_SLEEP;
			PLM_STOPPED: nxt_act = nxt_stop_mode;
			default:     nxt_act = plm_pkg::MODE_RX;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			act_ff  <= plm_pkg::MODE_STBY;
			rx_ff   <= 1'b0;
			rc_ff   <= 1'b0;
			lact_ff <= 1'b0;
			lstp_ff <= 1'b0;
		end else begin
			act_ff  <= nxt_act;
			rx_ff   <= rx_now;
			rc_ff   <= nxt_rc;
			lact_ff <= nxt_lact;
			lstp_ff <= nxt_lstp;
		end
	end

	assign active_mode_o        = act_ff;
	assign rx_on_o              = rx_ff;
	assign rc_only_o            = rc_ff;
	assign listen_active_o      = lact_ff;
	assign listen_stopped_o     = lstp_ff;
	assign queue_discard_o      = discard_ff;
	assign timeout_o            = to_ff;
	assign pattern_match_flag_o = match_ff;
	assign rc_trim_busy_o       = rc_busy_ff;
	assign rc_trim_finished_o   = rc_done_ff;
endmodule : plm_listen_ctrl

// ### logic/plm_pkg.sv
// What this block does
// - idle runs rc only, periodic receiver wake
// - no signal: receiver off until next period
// - signal accepted: receiver stays on, demodulating
// - receiver start-up counted inside rx window
// - phase time is coefficient times resolution
// - resolution codes 01, 10, 11 select step
// - acceptance: level, optionally plus pattern match
// - end action 00: stay rx, listen stops
// - end action 01: after payload/timeout go mode
// - end action 10: after payload/timeout resume idle
// - rc oscillator calibrated at power-up
// - trim trigger recalibrates, then sets finished flag
// - auto modes start and end at mode field
// - auto rx: checksum enters, queue-empty edge leaves
// - mode field decode: sleep, standby, synth, rx
// - timeout after count times 16 bit periods
// - pattern flag set on sync word match
package plm_pkg;
	localparam logic [2:0]  MODE_SLEEP = 3'h0;
	localparam logic [2:0]  MODE_STBY  = 3'h1;
	localparam logic [2:0]  MODE_SYNTH = 3'h2;
	localparam logic [2:0]  MODE_RX    = 3'h4;

	localparam logic [1:0]  RES_RSVD = 2'h0;
	localparam logic [1:0]  RES_FINE = 2'h1;
	localparam logic [1:0]  RES_MID  = 2'h2;
	localparam logic [1:0]  RES_LONG = 2'h3;

	localparam logic [1:0]  END_STAY   = 2'h0;
	localparam logic [1:0]  END_MODE   = 2'h1;
	localparam logic [1:0]  END_RESUME = 2'h2;

	localparam int          CLK_PERIOD_NS = 10;
	localparam int          RES_FINE_NS   = 64000;
	localparam int          RES_MID_NS    = 4100000;
	localparam int          RES_LONG_NS   = 262000000;
	localparam int          RES_FINE_CYC  = (RES_FINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RES_MID_CYC   = (RES_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RES_LONG_CYC  = (RES_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          BITS_PER_TIMEOUT_UNIT = 16;
	localparam int          RC_TRIM_CYC   = 1000;

	localparam logic        RC_BUSY_RST   = 1'b1;
	localparam logic        RC_DONE_RST   = 1'b0;

	typedef struct packed {
		logic [1:0] idle_res;
		logic [7:0] idle_coef;
		logic [1:0] rx_res;
		logic [7:0] rx_coef;
		logic       criteria;
		logic [1:0] end_action;
	} plm_listen_cfg_t;

	typedef struct packed {
		logic [2:0] mode;
		logic       listen_enable;
		logic       listen_cancel;
	} plm_op_mode_t;

	typedef struct packed {
		logic       enable;
		logic [2:0] intermediate;
	} plm_auto_cfg_t;
endpackage : plm_pkg

// ### logic/plm_phase_timer.sv
`timescale 1ns/10ps
module plm_phase_timer (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_i,
	input  wire logic        abort_i,
	input  wire logic [31:0] step_i,
	input  wire logic [7:0]  coef_i,
	output logic             done_o,
	output logic             busy_o
);
	logic [31:0] pre_ff,  nxt_pre;
	logic [7:0]  unit_ff, nxt_unit;
	logic [31:0] step_ff, nxt_step;
	logic [7:0]  coef_ff, nxt_coef;
	logic        busy_ff, nxt_busy;
	logic        done_ff, nxt_done;

	always_comb begin
		nxt_pre  = pre_ff;
		nxt_unit = unit_ff;
		nxt_step = step_ff;
		nxt_coef = coef_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (abort_i) begin
			nxt_busy = 1'b0;
		end else if (start_i) begin
			// a reserved step or zero coefficient leaves the timer idle
			nxt_busy = (step_i != 32'h0) && (coef_i != 8'h0);
			nxt_pre  = 32'h0;
			nxt_unit = 8'h0;
			nxt_step = step_i;
			nxt_coef = coef_i;
		end else if (busy_ff) begin
			if (pre_ff == step_ff - 32'h1) begin
				nxt_pre = 32'h0;
				// duration is coefficient whole steps
				if (unit_ff == coef_ff - 8'h1) begin
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
				end else begin
					nxt_unit = unit_ff + 8'h1;
				end
			end else begin
				nxt_pre = pre_ff + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pre_ff  <= 32'h0;
			unit_ff <= 8'h0;
			step_ff <= 32'h0;
			coef_ff <= 8'h0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			pre_ff  <= nxt_pre;
			unit_ff <= nxt_unit;
			step_ff <= nxt_step;
			coef_ff <= nxt_coef;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign done_o = done_ff;
	assign busy_o = busy_ff;
endmodule : plm_phase_timer

// ### test/plm_listen_ctrl_assertions.sv
`timescale 1ns/10ps
module plm_listen_ctrl_assertions (
	input wire logic                     clk_i,
	input wire logic                     rst_n_i,
	input wire plm_pkg::plm_op_mode_t    operating_mode_i,
	input wire plm_pkg::plm_listen_cfg_t listen_cfg_i,
	input wire logic                     rc_trim_trigger_i,
	input wire logic [2:0]               active_mode_o,
	input wire logic                     rx_on_o,
	input wire logic                     rc_only_o,
	input wire logic                     listen_active_o,
	input wire logic                     listen_stopped_o,
	input wire logic                     queue_discard_o,
	input wire logic                     timeout_o,
	input wire logic                     rc_trim_busy_o,
	input wire logic                     rc_trim_finished_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_idle_rx_off: assert property (
		rc_only_o |-> !rx_on_o && active_mode_o == plm_pkg::MODE_SLEEP)
		else $error("receiver on during idle phase");
	chk_discard_wake: assert property (
		queue_discard_o |-> rx_on_o && listen_active_o ##1 !queue_discard_o)
		else $error("queue discard outside a receive wake-up");
	chk_rx_mode: assert property (
		rx_on_o |-> active_mode_o == plm_pkg::MODE_RX)
		else $error("receiver on with mode not receive");
	chk_cancel_exit: assert property (
		listen_active_o && operating_mode_i.listen_cancel |=>
		!listen_active_o && active_mode_o == $past(operating_mode_i.mode))
		else $error("cancel did not leave listening");
	chk_stop_rx: assert property (
		$rose(listen_stopped_o) && listen_cfg_i.end_action == plm_pkg::END_STAY |-> rx_on_o)
		else $error("stopped without receiver on");
	chk_timeout_pulse: assert property (
		timeout_o |=> !timeout_o)
		else $error("timeout longer than one cycle");
	chk_trim_start: assert property (
		rc_trim_trigger_i |=> rc_trim_busy_o && !rc_trim_finished_o)
		else $error("trim trigger did not start calibration");
	chk_trim_done: assert property (
		$rose(rc_trim_finished_o) |-> $fell(rc_trim_busy_o))
		else $error("trim finished without busy falling");
	chk_reserved_hold: assert property (
		rc_only_o && listen_cfg_i.idle_res == plm_pkg::RES_RSVD &&
		operating_mode_i.listen_enable && !operating_mode_i.listen_cancel |=> rc_only_o)
		else $error("reserved resolution ended idle phase");
	cover property ($rose(listen_stopped_o));
	cover property (timeout_o);
	cover property (queue_discard_o);
endmodule : plm_listen_ctrl_assertions

bind plm_listen_ctrl plm_listen_ctrl_assertions u_plm_listen_ctrl_assertions (.*);

// ### test/plm_host_model.sv
`timescale 1ns/10ps
module plm_host_model (
	input  wire logic             clk_i,
	output plm_pkg::plm_op_mode_t operating_mode_o
);
	initial operating_mode_o = '{plm_pkg::MODE_STBY, 1'b0, 1'b0};
	// one write per edge, like one serial access per register write
	task automatic wr(input logic [2:0] m, input logic en, input logic cn);
		@(posedge clk_i);
		#1;
		operating_mode_o = '{m, en, cn};
	endtask : wr
	task automatic listen_on();
		wr(plm_pkg::MODE_STBY, 1'b0, 1'b0);
		wr(plm_pkg::MODE_STBY, 1'b1, 1'b0);
	endtask : listen_on
	task automatic abort(input logic [2:0] m);
		wr(m, 1'b0, 1'b1);
		wr(m, 1'b0, 1'b0);
	endtask : abort
	task automatic hop();
		wr(plm_pkg::MODE_SYNTH, 1'b0, 1'b0);
		wr(plm_pkg::MODE_RX, 1'b0, 1'b0);
	endtask : hop
endmodule : plm_host_model

// ### test/test_plm_listen_ctrl.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module test_plm_listen_ctrl;
	localparam int FINE = 8;
	localparam int MID = 16;
	localparam int LONG = 32;
	localparam int TRIM = 20;
	logic                     clk_i = 1'b0;
	logic                     rst_n_i = 1'b0;
	plm_pkg::plm_op_mode_t    operating_mode_i;
	plm_pkg::plm_listen_cfg_t listen_cfg_i = '0;
	plm_pkg::plm_auto_cfg_t   auto_cfg_i = '0;
	logic [7:0]               post_detect_timeout_count_i = 8'h00;
	logic                     signal_level_threshold_i = 1'b0;
	logic                     payload_complete_flag_i = 1'b0;
	logic                     checksum_good_flag_i = 1'b0;
	logic                     queue_has_bytes_i = 1'b0;
	logic                     bit_tick_i = 1'b0;
	logic                     bit_data_i = 1'b0;
	logic [7:0]               sync_word_i = 8'h5a;
	logic                     rc_trim_trigger_i = 1'b0;
	logic [2:0]               active_mode_o;
	logic rx_on_o, rc_only_o, listen_active_o, listen_stopped_o, queue_discard_o;
	logic timeout_o, pattern_match_flag_o, rc_trim_busy_o, rc_trim_finished_o;
	int                       n_errors = 0;
	int                       check_count = 0;
	int                       n;
	// short steps keep the longest resolution at a few dozen cycles
	plm_listen_ctrl #(.SYNC_W(8), .RES_FINE_CYC(FINE), .RES_MID_CYC(MID),
		.RES_LONG_CYC(LONG), .RC_TRIM_CYC(TRIM)) u_plm_listen_ctrl (.*);
	plm_host_model u_plm_host_model (.clk_i(clk_i), .operating_mode_o(operating_mode_i));
	always #5 clk_i = ~clk_i;
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : cyc
	function automatic logic pick(input int s);
		case (s)
			0: return rx_on_o;
			1: return rc_only_o;
			2: return timeout_o;
			default: return rc_trim_finished_o;
		endcase
	endfunction : pick
	task automatic wt(input int s, input logic v);
		n = 0;
		while (pick(s) !== v) begin
			cyc(1);
			n++;
			if (n > 3000) begin
				n_errors++;
				print_verdict();
			end
		end
	endtask : wt
	task automatic cfg(input logic [1:0] ir, input logic [7:0] rc, input logic cr,
		input logic [1:0] ea);
		listen_cfg_i = '{ir, 8'h02, plm_pkg::RES_FINE, rc, cr, ea};
	endtask : cfg
	task automatic t_trim();
		`CHK(active_mode_o, plm_pkg::MODE_STBY)
		`CHK(rc_trim_busy_o, 1'b1)
		wt(3, 1'b1);
		`CHK(n inside {[TRIM - 2 : TRIM + 2]}, 1'b1)
		rc_trim_trigger_i = 1'b1;
		cyc(1);
		rc_trim_trigger_i = 1'b0;
		`CHK({rc_trim_busy_o, rc_trim_finished_o}, 2'h2)
		wt(3, 1'b1);
		`CHK(n inside {[TRIM - 2 : TRIM + 1]}, 1'b1)
	endtask : t_trim
	task automatic t_modes();
		logic [2:0] m[4] = '{plm_pkg::MODE_SLEEP, plm_pkg::MODE_STBY,
			plm_pkg::MODE_SYNTH, plm_pkg::MODE_RX};
		foreach (m[i]) begin
			u_plm_host_model.wr(m[i], 1'b0, 1'b0);
			cyc(3);
			`CHK(active_mode_o, m[i])
			`CHK(rx_on_o, m[i] == plm_pkg::MODE_RX)
		end
		u_plm_host_model.hop();
		cyc(3);
		`CHK(rx_on_o, 1'b1)
		u_plm_host_model.wr(plm_pkg::MODE_STBY, 1'b0, 1'b0);
		cyc(3);
	endtask : t_modes
	task automatic t_phase();
		int s;
		for (int r = 1; r < 4; r++) begin
			s = (r == 1) ? FINE : (r == 2) ? MID : LONG;
			cfg(r[1:0], 8'h01, 1'b0, plm_pkg::END_RESUME);
			u_plm_host_model.listen_on();
			wt(1, 1'b1);
			wt(1, 1'b0);
			`CHK(n inside {[2 * s : 2 * s + 3]}, 1'b1)
			wt(0, 1'b1);
			`CHK(n < 3, 1'b1)
			wt(0, 1'b0);
			`CHK(n inside {[FINE - 1 : FINE + 1]}, 1'b1)
			wt(1, 1'b1);
			`CHK(n < 3, 1'b1)
			u_plm_host_model.abort(plm_pkg::MODE_STBY);
		end
	endtask : t_phase
	task automatic t_accept(input logic cr);
		cfg(plm_pkg::RES_FINE, 8'h04, cr, plm_pkg::END_STAY);
		u_plm_host_model.listen_on();
		wt(0, 1'b1);
		signal_level_threshold_i = 1'b1;
		if (cr) begin
			wt(0, 1'b0);
			`CHK(listen_stopped_o, 1'b0)
			wt(0, 1'b1);
			bit_tick_i = 1'b1;
			for (int i = 7; i >= 0; i--) begin
				bit_data_i = sync_word_i[i];
				cyc(1);
			end
			bit_tick_i = 1'b0;
		end
		cyc(3);
		`CHK(pattern_match_flag_o, cr)
		`CHK({listen_stopped_o, rx_on_o}, 2'h3)
		cyc(40);
		`CHK(rx_on_o, 1'b1)
		signal_level_threshold_i = 1'b0;
		u_plm_host_model.wr(plm_pkg::MODE_STBY, 1'b0, 1'b0);
		cyc(3);
		`CHK(listen_active_o, 1'b0)
	endtask : t_accept
	task automatic t_end(input logic [1:0] ea);
		cfg(plm_pkg::RES_FINE, 8'h01, 1'b0, ea);
		post_detect_timeout_count_i = 8'h01;
		u_plm_host_model.listen_on();
		wt(0, 1'b1);
		`CHK(queue_discard_o, 1'b1)
		signal_level_threshold_i = 1'b1;
		cyc(12);
		`CHK(rx_on_o, 1'b1)
		if (ea == plm_pkg::END_MODE) begin
			u_plm_host_model.wr(plm_pkg::MODE_SYNTH, 1'b1, 1'b0);
			// the mode field is taken one cycle late, so let it settle first
			cyc(1);
			payload_complete_flag_i = 1'b1;
			cyc(1);
			payload_complete_flag_i = 1'b0;
			cyc(3);
			`CHK({active_mode_o, listen_stopped_o}, {plm_pkg::MODE_SYNTH, 1'b1})
			`CHK(rx_on_o, 1'b0)
		end else begin
			bit_tick_i = 1'b1;
			wt(2, 1'b1);
			`CHK(n inside {[14 : 18]}, 1'b1)
			bit_tick_i = 1'b0;
			wt(1, 1'b1);
			`CHK(n < 4, 1'b1)
		end
		signal_level_threshold_i = 1'b0;
		u_plm_host_model.abort(plm_pkg::MODE_STBY);
		cyc(3);
	endtask : t_end
	task automatic t_auto();
		u_plm_host_model.wr(plm_pkg::MODE_RX, 1'b0, 1'b0);
		auto_cfg_i = '{1'b1, plm_pkg::MODE_SLEEP};
		queue_has_bytes_i = 1'b1;
		cyc(3);
		checksum_good_flag_i = 1'b1;
		cyc(1);
		checksum_good_flag_i = 1'b0;
		cyc(2);
		`CHK(active_mode_o, plm_pkg::MODE_SLEEP)
		u_plm_host_model.wr(plm_pkg::MODE_STBY, 1'b0, 1'b0);
		queue_has_bytes_i = 1'b0;
		cyc(3);
		`CHK(active_mode_o, plm_pkg::MODE_STBY)
		auto_cfg_i = '0;
	endtask : t_auto
	task automatic t_reserved();
		cfg(plm_pkg::RES_RSVD, 8'h01, 1'b0, plm_pkg::END_STAY);
		u_plm_host_model.listen_on();
		cyc(80);
		`CHK(rc_only_o, 1'b1)
		u_plm_host_model.abort(plm_pkg::MODE_SYNTH);
		cyc(3);
		`CHK({listen_active_o, active_mode_o}, {1'b0, plm_pkg::MODE_SYNTH})
		u_plm_host_model.wr(plm_pkg::MODE_STBY, 1'b0, 1'b0);
	endtask : t_reserved
	initial begin
		repeat (2) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		t_trim();
		t_modes();
		t_phase();
		t_accept(1'b0);
		t_accept(1'b1);
		t_end(plm_pkg::END_MODE);
		t_end(plm_pkg::END_RESUME);
		t_auto();
		t_reserved();
		print_verdict();
	end
endmodule : test_plm_listen_ctrl
